/* File: core/camera_trigger_and_cooling_ctrl.sv */
`timescale 1ns/100ps
`include "cam_ctrl_map.svh"

// How it works
// RULE1 - Exactly one acquisition mode at a time: free-running video or trigger.
// RULE2 - Trigger mode takes software commands or isolated, line zero, line one, counter, pulse generator.
// RULE3 - After the host opens the device it is in video mode until trigger is chosen.
// RULE4 - Video mode applies auto exposure, exposure target, exposure time and gain.
// RULE5 - Host sets a general line to input before choosing it as trigger source.
// RULE6 - Counter mode divides external trigger rate by a value from 1 to 1023.
// RULE7 - Counter fires once every N qualifying edges, then restarts from zero.
// RULE8 - Software trigger supports single, loop, multiple and sequence capture styles.
// RULE9 - One hardware trigger in sequence capture takes N frames with per-entry exposure and gain.
// RULE10 - Bandwidth limit settable from 1% to 100%, defaulting to 100%.
// RULE11 - Digital binning 1x1 to 8x8 sum or average; hardware binning 1x1 to 2x2 average.
// RULE12 - Cooler enabled by default and regulates toward the host target temperature.
// RULE13 - Fan has off and high; off also disables the cooler.
// RULE14 - Enabling the cooler switches the fan on.
// RULE15 - Switching the fan off disables the cooler.
module camera_trigger_and_cooling_ctrl
  import cam_ctrl_pkg::*;
#(
  parameter int SEQ_DEPTH = 16,
  parameter int EXP_W     = 24,
  parameter int GAIN_W    = 12,
  parameter int TEMP_W    = 12
)(
  input  wire logic                         sys_clk,
  input  wire logic                         resetn,
  input  wire logic                         host_open,
  input  wire logic                         trigger_mode_sel,
  input  wire logic [2:0]                   trigger_source,
  input  wire logic [1:0]                   capture_style,
  input  wire logic                         hw_sequence_en,
  input  wire logic [7:0]                   frame_count,
  input  wire logic                         sw_trigger,
  input  wire logic                         capture_stop,
  input  wire logic                         frame_done,
  input  wire logic                         isolated_in,
  input  wire logic                         general_line_zero_in,
  input  wire logic                         general_line_one_in,
  input  wire logic                         general_line_zero_is_input,
  input  wire logic                         general_line_one_is_input,
  input  wire logic                         pulse_gen_tick,
  input  wire logic [9:0]                   counter_value,
  input  wire logic                         seq_wr_en,
  input  wire logic [$clog2(SEQ_DEPTH)-1:0] seq_wr_index,
  input  wire logic [EXP_W-1:0]             seq_wr_exposure,
  input  wire logic [GAIN_W-1:0]            seq_wr_gain,
  input  wire logic [$clog2(SEQ_DEPTH)-1:0] seq_length,
  input  wire logic                         auto_exposure,
  input  wire logic [7:0]                   exposure_target,
  input  wire logic [EXP_W-1:0]             exposure_time,
  input  wire logic [GAIN_W-1:0]            gain,
  input  wire logic                         bandwidth_set,
  input  wire logic [6:0]                   bandwidth_pct,
  input  wire logic                         binning_set,
  input  wire logic [3:0]                   digital_bin,
  input  wire logic                         digital_bin_sum,
  input  wire logic [1:0]                   hardware_bin,
  input  wire logic                         cooler_set,
  input  wire logic                         cooler_value,
  input  wire logic                         fan_set,
  input  wire logic                         fan_value,
  input  wire logic [TEMP_W-1:0]            target_temp,
  output logic                              trigger_mode_q,
  output logic                              frame_start_q,
  output logic                              capture_busy_q,
  output logic [EXP_W-1:0]                  frame_exposure_q,
  output logic [GAIN_W-1:0]                 frame_gain_q,
  output logic                              auto_exposure_q,
  output logic [7:0]                        exposure_target_q,
  output logic [6:0]                        bandwidth_q,
  output logic [3:0]                        digital_bin_q,
  output logic                              digital_bin_sum_q,
  output logic [1:0]                        hardware_bin_q,
  output logic                              thermoelectric_cooler_on_q,
  output logic                              fan_high_q,
  output logic [TEMP_W-1:0]                 cooler_target_q
);

  localparam int IW = $clog2(SEQ_DEPTH);

  if (SEQ_DEPTH < 2 || EXP_W < 1 || GAIN_W < 1 || TEMP_W < 1)
  begin : g_bad_param
    $error("camera_trigger_and_cooling_ctrl: unsupported parameter values");
  end

  // Two-stage synchronisers for the trigger pins, plus a third stage for edges.
  logic [`CAM_PIN_COUNT-1:0] pin_raw;
  logic [`CAM_PIN_COUNT-1:0] pin_meta_q;
  logic [`CAM_PIN_COUNT-1:0] pin_sync_q;
  logic [`CAM_PIN_COUNT-1:0] pin_prev_q;
  logic [`CAM_PIN_COUNT-1:0] pin_rise;

  assign pin_raw[`CAM_PIN_ISOLATED]  = isolated_in;
  assign pin_raw[`CAM_PIN_LINE_ZERO] = general_line_zero_in;
  assign pin_raw[`CAM_PIN_LINE_ONE]  = general_line_one_in;

  for (genvar i = 0; i < `CAM_PIN_COUNT; i++)
  begin : g_sync
    always_ff @(posedge sys_clk)
    begin
      pin_meta_q[i] <= resetn ? pin_raw[i] : 1'b0;
      pin_sync_q[i] <= resetn ? pin_meta_q[i] : 1'b0;
      pin_prev_q[i] <= resetn ? pin_sync_q[i] : 1'b0;
    end
    assign pin_rise[i] = pin_sync_q[i] & ~pin_prev_q[i];
  end

  // Mode: opening forces video mode, trigger mode only on explicit selection.
  logic trigger_mode_d;
  assign trigger_mode_d = host_open ? 1'b0 : trigger_mode_sel;  // [RULE1] [RULE3]

  // Counter divides isolated-input edges; a value of zero is served as one.
  logic [9:0] counter_cnt_q;
  logic [9:0] counter_lim;
  logic       counter_edge;
  logic       counter_fire;
  assign counter_lim  = (counter_value < `CAM_COUNTER_MIN) ? `CAM_COUNTER_MIN : counter_value;  // [RULE6]
  assign counter_edge = pin_rise[`CAM_PIN_ISOLATED] && trigger_mode_q
                        && (trigger_source == SRC_COUNTER);
  assign counter_fire = counter_edge && (counter_cnt_q + 10'h001 >= counter_lim);  // [RULE7]

  // A general line only qualifies once the host has set it to input.
  logic hw_trigger;
  assign hw_trigger = trigger_mode_q && (
      (trigger_source == SRC_ISOLATED  && pin_rise[`CAM_PIN_ISOLATED])
    || (trigger_source == SRC_LINE_ZERO && general_line_zero_is_input
        && pin_rise[`CAM_PIN_LINE_ZERO])  // [RULE5]
    || (trigger_source == SRC_LINE_ONE  && general_line_one_is_input
        && pin_rise[`CAM_PIN_LINE_ONE])   // [RULE5]
    || (trigger_source == SRC_COUNTER   && counter_fire)
    || (trigger_source == SRC_PULSE_GEN && pulse_gen_tick));  // [RULE2]

  logic sw_go;
  assign sw_go = trigger_mode_q && (trigger_source == SRC_SOFTWARE) && sw_trigger;  // [RULE2]

  // Sequence table of exposure and gain per entry.
  logic [EXP_W-1:0]  seq_exp_mem  [SEQ_DEPTH];
  logic [GAIN_W-1:0] seq_gain_mem [SEQ_DEPTH];

  always_ff @(posedge sys_clk)
  begin
    if (seq_wr_en)
    begin
      seq_exp_mem[seq_wr_index]  <= seq_wr_exposure;
      seq_gain_mem[seq_wr_index] <= seq_wr_gain;
    end
  end

  // Capture sequencer.
  cap_state_t     state_q;
  cap_state_t     state_d;
  capture_style_t style_q;
  logic [7:0]     frames_left_q;
  logic [IW-1:0]  seq_idx_q;
  logic           use_table_q;
  logic           start_req;
  logic           hw_is_seq;
  logic           more_frames;
  logic [7:0]     burst_len;
  logic [IW-1:0]  seq_idx_next;

  assign start_req    = (state_q == ST_IDLE) && (sw_go || hw_trigger);
  assign hw_is_seq    = hw_sequence_en || (capture_style == STYLE_SEQUENCE);  // [RULE9]
  assign burst_len    = (frame_count == 8'h00) ? 8'h01 : frame_count;
  assign more_frames  = (style_q == STYLE_LOOP) ? !capture_stop : (frames_left_q > 8'h01);
  assign seq_idx_next = (seq_idx_q >= seq_length) ? '0 : IW'(seq_idx_q + 1'b1);

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:   if (start_req) state_d = ST_START;
      ST_START:  state_d = ST_EXPOSE;
      ST_EXPOSE:
      begin
        if (!trigger_mode_q)
          state_d = ST_IDLE;
        else if (frame_done)
          state_d = more_frames ? ST_START : ST_IDLE;
      end
      default:   state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      state_q        <= ST_IDLE;
      style_q        <= STYLE_SINGLE;
      frames_left_q  <= 8'h00;
      seq_idx_q      <= '0;
      use_table_q    <= 1'b0;
      trigger_mode_q <= 1'b0;
      counter_cnt_q  <= 10'h000;
      frame_start_q  <= 1'b0;
      capture_busy_q <= 1'b0;
    end
    else
    begin
      state_q        <= state_d;
      trigger_mode_q <= trigger_mode_d;
      frame_start_q  <= (state_q == ST_START);
      capture_busy_q <= (state_d != ST_IDLE);
      if (counter_edge)
        counter_cnt_q <= counter_fire ? 10'h000 : counter_cnt_q + 10'h001;  // [RULE7]
      else if (!trigger_mode_q || trigger_source != SRC_COUNTER)
        counter_cnt_q <= 10'h000;
      if (start_req && sw_go)
      begin
        style_q       <= capture_style_t'(capture_style);  // [RULE8]
        frames_left_q <= (capture_style == STYLE_SINGLE) ? 8'h01 : burst_len;
        use_table_q   <= (capture_style == STYLE_SEQUENCE);
      end
      else if (start_req)
      begin
        style_q       <= hw_is_seq ? STYLE_SEQUENCE : STYLE_SINGLE;
        frames_left_q <= hw_is_seq ? burst_len : 8'h01;  // [RULE9]
        use_table_q   <= hw_is_seq;
      end
      else if (state_q == ST_EXPOSE && frame_done && frames_left_q != 8'h00)
        frames_left_q <= frames_left_q - 8'h01;
      // The table index carries over between bursts so leftover entries run next time.
      if (state_q == ST_START && use_table_q)
        seq_idx_q <= seq_idx_next;  // [RULE9]
    end
  end

  // Per-frame exposure and gain; video mode uses the host settings directly.
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      frame_exposure_q  <= '0;
      frame_gain_q      <= '0;
      auto_exposure_q   <= 1'b0;
      exposure_target_q <= 8'h00;
    end
    else if (!trigger_mode_q)
    begin
      frame_exposure_q  <= exposure_time;  // [RULE4]
      frame_gain_q      <= gain;
      auto_exposure_q   <= auto_exposure;
      exposure_target_q <= exposure_target;
    end
    else
    begin
      auto_exposure_q <= 1'b0;
      if (state_q == ST_START)
      begin
        frame_exposure_q <= use_table_q ? seq_exp_mem[seq_idx_q] : exposure_time;  // [RULE9]
        frame_gain_q     <= use_table_q ? seq_gain_mem[seq_idx_q] : gain;
      end
    end
  end

  // Bandwidth and binning: out-of-range writes are clamped rather than ignored.
  logic [6:0] bw_clamped;
  logic [3:0] dbin_clamped;
  logic [1:0] hbin_clamped;
  assign bw_clamped   = (bandwidth_pct < `CAM_BANDWIDTH_MIN) ? `CAM_BANDWIDTH_MIN :
                        (bandwidth_pct > `CAM_BANDWIDTH_MAX) ? `CAM_BANDWIDTH_MAX : bandwidth_pct;
  assign dbin_clamped = (digital_bin < `CAM_DBIN_MIN) ? `CAM_DBIN_MIN :
                        (digital_bin > `CAM_DBIN_MAX) ? `CAM_DBIN_MAX : digital_bin;
  assign hbin_clamped = (hardware_bin < `CAM_HBIN_MIN) ? `CAM_HBIN_MIN :
                        (hardware_bin > `CAM_HBIN_MAX) ? `CAM_HBIN_MAX : hardware_bin;

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      bandwidth_q       <= `CAM_BANDWIDTH_RST;  // [RULE10]
      digital_bin_q     <= `CAM_DBIN_MIN;
      digital_bin_sum_q <= 1'b0;
      hardware_bin_q    <= `CAM_HBIN_MIN;
    end
    else
    begin
      if (bandwidth_set)
        bandwidth_q <= bw_clamped;  // [RULE10]
      if (binning_set)
      begin
        digital_bin_q     <= dbin_clamped;  // [RULE11]
        digital_bin_sum_q <= digital_bin_sum;
        hardware_bin_q    <= hbin_clamped;
      end
    end
  end

  // Cooler and fan interlock; a fan-off request wins over a cooler-on request.
  logic fan_off_req;
  logic cooler_on_req;
  assign fan_off_req   = fan_set && !fan_value;
  assign cooler_on_req = cooler_set && cooler_value;

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      thermoelectric_cooler_on_q <= `CAM_COOLER_RST;  // [RULE12]
      fan_high_q                 <= `CAM_FAN_RST;
      cooler_target_q            <= '0;
    end
    else
    begin
      cooler_target_q <= target_temp;  // [RULE12]
      if (fan_off_req)
      begin
        fan_high_q                 <= 1'b0;  // [RULE13]
        thermoelectric_cooler_on_q <= 1'b0;  // [RULE15]
      end
      else if (cooler_on_req)
      begin
        thermoelectric_cooler_on_q <= 1'b1;
        fan_high_q                 <= 1'b1;  // [RULE14]
      end
      else
      begin
        if (cooler_set)
          thermoelectric_cooler_on_q <= 1'b0;
        if (fan_set)
          fan_high_q <= 1'b1;
      end
    end
  end

endmodule

/* File: core/cam_ctrl_map.svh */
`ifndef CAM_CTRL_MAP_SVH
`define CAM_CTRL_MAP_SVH

// Reset values and limits of the host-visible settings.
`define CAM_BANDWIDTH_RST   7'h64
`define CAM_BANDWIDTH_MIN   7'h01
`define CAM_BANDWIDTH_MAX   7'h64
`define CAM_DBIN_MIN        4'h1
`define CAM_DBIN_MAX        4'h8
`define CAM_HBIN_MIN        2'h1
`define CAM_HBIN_MAX        2'h2
`define CAM_COUNTER_MIN     10'h001
`define CAM_COUNTER_MAX     10'h3FF
`define CAM_COOLER_RST      1'b1
`define CAM_FAN_RST         1'b1

// Bit positions of the synchronised trigger pins.
`define CAM_PIN_ISOLATED    0
`define CAM_PIN_LINE_ZERO   1
`define CAM_PIN_LINE_ONE    2
`define CAM_PIN_COUNT       3

`endif

/* File: core/cam_ctrl_pkg.sv */
package cam_ctrl_pkg;

  typedef enum logic [2:0] {
    SRC_SOFTWARE  = 3'b000,
    SRC_ISOLATED  = 3'b001,
    SRC_LINE_ZERO = 3'b010,
    SRC_LINE_ONE  = 3'b011,
    SRC_COUNTER   = 3'b100,
    SRC_PULSE_GEN = 3'b101
  } trig_src_t;

  typedef enum logic [1:0] {
    STYLE_SINGLE   = 2'b00,
    STYLE_LOOP     = 2'b01,
    STYLE_MULTIPLE = 2'b10,
    STYLE_SEQUENCE = 2'b11
  } capture_style_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_START  = 2'b01,
    ST_EXPOSE = 2'b10
  } cap_state_t;

endpackage

/* File: tb/sensor_model.sv */
`timescale 1ns/100ps
// Sensor side: answers each frame start with one frame_done pulse after lat cycles.
// The latency is a port so the bench can make the sensor prompt or slow.
module sensor_model (
  input  wire logic       sys_clk,
  input  wire logic       frame_start_q,
  input  wire logic [3:0] lat,
  output logic            frame_done
);
  int cnt = 0;
  initial frame_done = 1'b0;
  always @(posedge sys_clk)
  begin
    frame_done <= 1'b0;
    if (frame_start_q)
      cnt <= lat;
    else if (cnt > 1)
      cnt <= cnt - 1;
    else if (cnt == 1)
    begin
      frame_done <= 1'b1;
      cnt <= 0;
    end
  end
endmodule

/* File: tb/cam_ctrl_monitor.sv */
`timescale 1ns/100ps
module cam_ctrl_monitor (
  input wire logic       sys_clk,
  input wire logic       resetn,
  input wire logic       host_open,
  input wire logic [2:0] trigger_source,
  input wire logic       sw_trigger,
  input wire logic       cooler_set,
  input wire logic       cooler_value,
  input wire logic       fan_set,
  input wire logic       fan_value,
  input wire logic       trigger_mode_q,
  input wire logic       frame_start_q,
  input wire logic       capture_busy_q,
  input wire logic [6:0] bandwidth_q,
  input wire logic [3:0] digital_bin_q,
  input wire logic [1:0] hardware_bin_q,
  input wire logic       thermoelectric_cooler_on_q,
  input wire logic       fan_high_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_taken;
    trigger_mode_q && !capture_busy_q && sw_trigger && trigger_source == 3'h0;
  endsequence
  sequence s_launch;
    capture_busy_q && !frame_start_q ##1 frame_start_q ##1 !frame_start_q;
  endsequence
  chk_open_video: assert property (host_open |=> !trigger_mode_q) else $error("open left trigger mode");
  chk_sw_launch: assert property (s_taken |=> s_launch)
    else $error("software trigger not launched");
  chk_start_mode: assert property (frame_start_q |-> capture_busy_q && $past(trigger_mode_q, 2))
    else $error("frame outside trigger capture");
  chk_bw_range: assert property (
    bandwidth_q >= 7'h01 && bandwidth_q <= 7'h64) else $error("bandwidth out of range");
  chk_bin_range: assert property (
    digital_bin_q inside {[4'h1:4'h8]} && hardware_bin_q inside {[2'h1:2'h2]}) else $error("binning out of range");
  chk_fan_off: assert property (
    fan_set && !fan_value |=> !fan_high_q && !thermoelectric_cooler_on_q) else $error("fan off kept cooler");
  chk_cooler_fan: assert property (thermoelectric_cooler_on_q |-> fan_high_q)
    else $error("cooler without fan");
  chk_cooler_on: assert property (
    cooler_set && cooler_value && !(fan_set && !fan_value) |=> thermoelectric_cooler_on_q && fan_high_q)
    else $error("cooler on ignored");
endmodule

bind camera_trigger_and_cooling_ctrl cam_ctrl_monitor i_cam_ctrl_monitor (.*);

/* File: tb/testbench.sv */
`timescale 1ns/100ps
module testbench;
  import cam_ctrl_pkg::*;
  logic sys_clk, resetn, host_open, trigger_mode_sel, hw_sequence_en, sw_trigger, capture_stop, frame_done;
  logic isolated_in, general_line_zero_in, general_line_one_in, general_line_zero_is_input;
  logic general_line_one_is_input, pulse_gen_tick, seq_wr_en, auto_exposure, bandwidth_set, binning_set;
  logic digital_bin_sum, cooler_set, cooler_value, fan_set, fan_value;
  logic trigger_mode_q, frame_start_q, capture_busy_q, auto_exposure_q, digital_bin_sum_q;
  logic thermoelectric_cooler_on_q, fan_high_q;
  logic [2:0]  trigger_source;
  logic [1:0]  capture_style, hardware_bin, hardware_bin_q;
  logic [7:0]  frame_count, exposure_target, exposure_target_q;
  logic [9:0]  counter_value;
  logic [3:0]  seq_wr_index, seq_length, digital_bin, digital_bin_q, lat;
  logic [23:0] seq_wr_exposure, exposure_time, frame_exposure_q;
  logic [11:0] seq_wr_gain, gain, frame_gain_q, target_temp, cooler_target_q;
  logic [6:0]  bandwidth_pct, bandwidth_q;
  logic [15:0] rnd = 16'h002D;
  logic [35:0] exp_q[$];
  logic [35:0] tab[3];
  int error_cnt = 0;
  int total_checks = 0;
  int i, k, v, e;

  camera_trigger_and_cooling_ctrl i_camera_trigger_and_cooling_ctrl (.*);
  sensor_model i_sensor_model (.sys_clk(sys_clk), .frame_start_q(frame_start_q), .lat(lat), .frame_done(frame_done));

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask

  task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    if (error_cnt == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Pins are held two cycles so the synchronisers cannot miss them; the gap outlasts a slow frame.
  task automatic pulse(input int src);
    case (src)
      1: isolated_in = 1'b1;
      2: general_line_zero_in = 1'b1;
      3: general_line_one_in = 1'b1;
      default: pulse_gen_tick = 1'b1;
    endcase
    tick(1);
    pulse_gen_tick = 1'b0;
    tick(1);
    {isolated_in, general_line_zero_in, general_line_one_in} = 3'h0;
    tick(14);
  endtask

  task automatic idle;
    tick(2);
    for (k = 0; k < 300 && capture_busy_q !== 1'b0; k++)
      tick(1);
    cmp(k == 300, 0);
    cmp(exp_q.size(), 0);
  endtask

  task automatic sw;
    sw_trigger = 1'b1;
    tick(1);
    sw_trigger = 1'b0;
    tick(1);
  endtask

  task automatic pulse_set(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(1);
  endtask

  // Every frame start is matched against the next expected exposure and gain.
  initial
    forever
    begin
      @(posedge sys_clk);
      #1;
      if (frame_start_q === 1'b1)
      begin
        if (exp_q.size() == 0)
          cmp(1, 0);
        else
          cmp({frame_exposure_q, frame_gain_q}, exp_q.pop_front());
      end
    end

  initial
  begin
    #(50 * 20000);
    cmp(1, 0);
    summarize;
  end

  initial
  begin
    {host_open, trigger_mode_sel, hw_sequence_en, sw_trigger, capture_stop, isolated_in, general_line_zero_in,
     general_line_one_in, general_line_zero_is_input, general_line_one_is_input, pulse_gen_tick, seq_wr_en,
     auto_exposure, bandwidth_set, binning_set, digital_bin_sum, cooler_set, cooler_value, fan_set,
     fan_value, trigger_source, capture_style, hardware_bin, seq_wr_index, digital_bin, seq_wr_exposure,
     seq_wr_gain, bandwidth_pct} = '0;
    {exposure_target, counter_value, seq_length, exposure_time, gain, target_temp} = '0;
    frame_count = 8'h01;
    lat = 4'h1;
    resetn = 1'b0;
    tick(3);
    resetn = 1'b1;
    tick(1);
    cmp({trigger_mode_q, bandwidth_q, digital_bin_q, hardware_bin_q, thermoelectric_cooler_on_q, fan_high_q},
        {1'b0, 7'h64, 4'h1, 2'h1, 2'h3});
    auto_exposure = 1'b1;
    exposure_target = 8'h5A;
    sw;
    tick(2);
    cmp({auto_exposure_q, exposure_target_q, capture_busy_q}, {1'b1, 8'h5A, 1'b0});
    {general_line_zero_is_input, general_line_one_is_input} = 2'h3;
    trigger_mode_sel = 1'b1;
    tick(2);
    cmp({trigger_mode_q, auto_exposure_q}, 2'h2);
    for (i = 0; i < 3; i++)
    begin
      rnd = nxt(rnd);
      exposure_time = {8'h00, rnd};
      gain = rnd[11:0];
      capture_style = i[1:0];
      frame_count = 8'h03;
      capture_stop = (i == 1);
      lat = (i == 2) ? 4'h5 : 4'h1;
      repeat ((i == 2) ? 3 : 1) exp_q.push_back({exposure_time, gain});
      sw;
      sw; // dropped while busy
      idle;
    end
    capture_stop = 1'b0;
    capture_style = 2'h0;
    for (i = 1; i < 6; i++)
      if (i != 4)
      begin
        trigger_source = i[2:0];
        exp_q.push_back({exposure_time, gain});
        pulse(i);
        idle;
      end
    trigger_source = 3'h4;
    for (v = 1; v < 4; v += 2)
    begin
      counter_value = v[9:0];
      repeat (2) exp_q.push_back({exposure_time, gain});
      repeat (2 * v) pulse(1);
      idle;
    end
    for (i = 0; i < 3; i++)
    begin
      rnd = nxt(rnd);
      tab[i] = {8'h00, rnd, rnd[15:4]};
      {seq_wr_index, seq_wr_exposure, seq_wr_gain} = {i[3:0], tab[i]};
      pulse_set(seq_wr_en);
    end
    {seq_length, trigger_source, capture_style, frame_count} = {4'h2, 3'h1, 2'h3, 8'h02};
    exp_q = '{tab[0], tab[1]};
    pulse(1);
    idle;
    capture_style = 2'h0;
    hw_sequence_en = 1'b1;
    exp_q = '{tab[2], tab[0]};
    pulse(1);
    idle;
    host_open = 1'b1;
    tick(1);
    {host_open, trigger_mode_sel} = 2'h0;
    cmp(trigger_mode_q, 0);
    for (i = 0; i < 4; i++)
    begin
      rnd = nxt(rnd);
      v = (i == 0) ? 0 : (i == 1) ? 101 : (i == 2) ? 127 : rnd % 100 + 1;
      e = (v < 1) ? 1 : (v > 100) ? 100 : v;
      bandwidth_pct = v[6:0];
      pulse_set(bandwidth_set);
      cmp(bandwidth_q, e[6:0]);
      {digital_bin, hardware_bin, digital_bin_sum} = {i[1] ? 4'h5 : (i[0] ? 4'h9 : 4'h0), i[1:0], i[0]};
      pulse_set(binning_set);
      cmp({digital_bin_q, hardware_bin_q, digital_bin_sum_q},
          {i[1] ? 4'h5 : (i[0] ? 4'h8 : 4'h1), (i == 0) ? 2'h1 : (i == 1) ? 2'h1 : 2'h2, i[0]});
    end
    target_temp = 12'hABC;
    for (i = 0; i < 5; i++)
    begin
      {fan_set, fan_value, cooler_set, cooler_value} = (i == 0) ? 4'h8 : (i == 2) ? 4'h2 : (i == 3) ? 4'hB : 4'h3;
      tick(1);
      {fan_set, cooler_set} = 2'h0;
      tick(1);
      cmp({thermoelectric_cooler_on_q, fan_high_q},
          (i == 2) ? 2'h1 : (i == 1 || i == 4) ? 2'h3 : 2'h0);
    end
    cmp(cooler_target_q, 12'hABC);
    summarize;
  end
endmodule
